// [verif/wdcm_testbench.sv]
// Purpose: Self-checking bench for the windowed watchdog and clock monitor
// Assumes: Pad has a pull-up; idle_tick pulsed every cycle to keep runs short
// Notes: Fault hold is measured from oe rise to oe release at the pad
`timescale 1ns/100ps
module testbench;
   import wdcm_pkg::*;

   // ============================================================
   // Signals and design instance
   logic ref_clk, rst_n, wd_option_dis, halt_mode, idle_mode, boot_entry;
   logic idle_tick, clk_rate_low, svc_wr, fault_pin_i, fault_pin_o, fault_pin_oe;
   logic [7:0] svc_wdata, svc_rdata;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   int oe_cyc = 0;

   wdcm_top u_wdcm_top (.ref_clk(ref_clk), .rst_n(rst_n), .wd_option_dis(wd_option_dis),
      .halt_mode(halt_mode), .idle_mode(idle_mode), .boot_entry(boot_entry),
      .idle_tick(idle_tick), .clk_rate_low(clk_rate_low), .svc_wr(svc_wr),
      .svc_wdata(svc_wdata), .svc_rdata(svc_rdata), .fault_pin_i(fault_pin_i),
      .fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe));

   // Pad level: pull-up unless the block drives it
   assign fault_pin_i = fault_pin_oe ? fault_pin_o : 1'b1;

   // ============================================================
   // Clock and hang guard
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Longest run is a few 16k windows; cut well above that
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   // ============================================================
   // Shared tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("errors=%0d compares=%0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish

   // Idle ticks back to back; counts cycles with the pin driven
   task automatic tick(input int n);
      idle_tick <= 1'b1;
      repeat (n) begin
         @(posedge ref_clk);
         if (fault_pin_oe === 1'b1) oe_cyc++;
      end
      idle_tick <= 1'b0;
   endtask : tick

   task automatic svc(input logic [7:0] d);
      @(posedge ref_clk);
      svc_wr <= 1'b1;
      svc_wdata <= d;
      @(posedge ref_clk);
      svc_wr <= 1'b0;
   endtask : svc

   // Wait for the pin to be driven, then time its release
   task automatic expect_fault(input bit wr, input bit rate);
      int n;
      int off;
      n = 0;
      off = rate ? 3 : 0;
      repeat (4) @(posedge ref_clk) if (fault_pin_oe === 1'b1) break;
      chk({7'h0, fault_pin_oe}, 8'h01);
      forever @(posedge ref_clk) begin
         if (fault_pin_oe !== 1'b1 || n > 100) break;
         n++;
         // A service while the pin is low must be dropped
         svc_wr <= wr && n == 3;
         svc_wdata <= 8'h58;
         if (rate && n == 3) clk_rate_low <= 1'b0;
      end
      chk(8'(n >= 16 + off && n <= 34 + off), 8'h01);
      repeat (4) @(posedge ref_clk);
   endtask : expect_fault

   // ============================================================
   // Scenarios
   task automatic t_monitor;
      chk(svc_rdata, 8'hC1);
      chk({7'h0, fault_pin_oe}, 8'h00);
      clk_rate_low <= 1'b1;
      repeat (10) @(posedge ref_clk);
      expect_fault(1'b0, 1'b1);
   endtask : t_monitor

   task automatic t_lock;
      svc(8'h58);
      @(posedge ref_clk);
      chk(svc_rdata, 8'h40);
      oe_cyc = 0;
      clk_rate_low <= 1'b1;
      tick(10);
      clk_rate_low <= 1'b0;
      chk(8'(oe_cyc), 8'h00);
   endtask : t_lock

   task automatic t_lower;
      tick(100);
      svc(8'h58);
      expect_fault(1'b1, 1'b0);
      oe_cyc = 0;
      tick(2100);
      svc(8'h58);
      tick(20);
      chk(8'(oe_cyc), 8'h00);
      chk(svc_rdata, 8'h40);
   endtask : t_lower

   task automatic t_upper;
      oe_cyc = 0;
      // 20 ticks already ran since the last restart; 16k limit
      tick(16363);
      chk(8'(oe_cyc), 8'h00);
      tick(1);
      expect_fault(1'b0, 1'b0);
   endtask : t_upper

   task automatic t_fields;
      logic [7:0] bad [3] = '{8'h40, 8'h98, 8'h59};
      foreach (bad[i]) begin
         tick(2100);
         svc(bad[i]);
         expect_fault(1'b0, 1'b0);
      end
   endtask : t_fields

   task automatic t_boot_idle;
      oe_cyc = 0;
      tick(2100);
      svc(8'h58);
      @(posedge ref_clk);
      boot_entry <= 1'b1;
      @(posedge ref_clk);
      boot_entry <= 1'b0;
      tick(10);
      svc(8'h58);
      tick(16000);
      idle_mode <= 1'b1;
      tick(1000);
      idle_mode <= 1'b0;
      halt_mode <= 1'b1;
      tick(500);
      halt_mode <= 1'b0;
      tick(2100);
      svc(8'h58);
      tick(20);
      chk(8'(oe_cyc), 8'h00);
   endtask : t_boot_idle

   task automatic t_option;
      oe_cyc = 0;
      wd_option_dis <= 1'b1;
      svc(8'h40);
      tick(20);
      chk(8'(oe_cyc), 8'h00);
   endtask : t_option

   // ============================================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      wd_option_dis = 1'b0;
      halt_mode = 1'b0;
      idle_mode = 1'b0;
      boot_entry = 1'b0;
      idle_tick = 1'b0;
      clk_rate_low = 1'b0;
      svc_wr = 1'b0;
      svc_wdata = 8'h00;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_monitor();
      t_lock();
      t_lower();
      t_upper();
      t_fields();
      t_boot_idle();
      t_option();
      tally_and_finish();
   end
endmodule : testbench

// [verilog/wdcm_pkg.sv]
// Purpose: Constants, state and field layout for the windowed watchdog
// Assumes: Window counts are in idle-timer ticks; release delay in ref_clk cycles
// Notes: Shared by the watchdog core and its assertions
package wdcm_pkg;

   // ============================================================
   // Service word field layout
   localparam int WIN_MSB = 7;
   localparam int WIN_LSB = 6;
   localparam int KEY_MSB = 5;
   localparam int KEY_LSB = 1;
   localparam int CM_BIT = 0;
   localparam logic [4:0] KEY_VAL = 5'h0C;
   localparam logic [4:0] KEY_READ = 5'h00;

   // ============================================================
   // Reset values
   localparam logic [1:0] WIN_RST = 2'h3;
   localparam logic CM_RST = 1'b1;

   // ============================================================
   // Timing counts
   localparam logic [16:0] LOWER_TICKS = 17'h0_0800;
   localparam logic [16:0] UPPER_BASE = 17'h0_2000;
   localparam int REL_MIN = 16;
   localparam int REL_MAX = 32;
   localparam int REL_MID = (REL_MIN + REL_MAX) / 2;
   localparam logic [5:0] REL_CYC = 6'(REL_MID);

   // ============================================================
   // Watchdog fault sequence
   typedef enum logic [1:0] {WD_RUN, WD_DRIVE, WD_HOLD, WD_WAIT} wdcm_wd_t;

   typedef struct packed {
      logic locked;
      logic [1:0] win;
      logic cm_en;
      logic low_en;
      logic [16:0] cnt;
      wdcm_wd_t st;
      logic [5:0] hold;
      logic [5:0] cm_hold;
      logic cm_drv;
      logic pin_s1;
      logic pin_s2;
      logic rate_s1;
      logic rate_s2;
      logic lp_q;
      logic oe;
   } wdcm_state_t;

endpackage : wdcm_pkg

// [verilog/wdcm_top.sv]
// Purpose: Windowed watchdog with clock monitor and open-drain fault pin
// Assumes: ref_clk is the instruction clock; idle_tick is one ref_clk wide
// Notes: Fault pin is driven low only; the pad pull-up makes it high
`timescale 1ns/100ps
module wdcm_top
   import wdcm_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Option and mode controls, ref_clk domain
   input wire logic wd_option_dis,
   input wire logic halt_mode,
   input wire logic idle_mode,
   input wire logic boot_entry,
   input wire logic idle_tick,
   // Slow clock detector, asynchronous
   input wire logic clk_rate_low,
   // Service word access
   input wire logic svc_wr,
   input wire logic [7:0] svc_wdata,
   output logic [7:0] svc_rdata,
   // Fault pin
   input wire logic fault_pin_i,
   output logic fault_pin_o,
   output logic fault_pin_oe
);

   // ============================================================
   // State and decode
   wdcm_state_t s_q;
   wdcm_state_t s_d;
   logic wd_en;
   logic low_pwr;
   logic lp_exit;
   logic tick_run;
   logic pin_low;
   logic cm_err;
   logic accept;
   logic key_bad;
   logic cfg_bad;
   logic too_early;
   logic [16:0] upper;
   logic [16:0] cnt_inc;

   // Option bit gates the whole block
   assign wd_en = ~wd_option_dis;
   assign low_pwr = halt_mode | idle_mode;
   assign lp_exit = s_q.lp_q & ~low_pwr;
   // Counting frozen in low-power modes
   assign tick_run = idle_tick & ~low_pwr;
   assign pin_low = ~s_q.pin_s2;
   // Detector output is filtered externally; here only enable gating
   assign cm_err = s_q.cm_en & s_q.rate_s2;
   // Ignored unless running and pin released
   assign accept = svc_wr & wd_en & (s_q.st == WD_RUN) & ~pin_low;
   assign key_bad = svc_wdata[KEY_MSB:KEY_LSB] != KEY_VAL;
   assign cfg_bad = (svc_wdata[WIN_MSB:WIN_LSB] != s_q.win)
                  | (svc_wdata[CM_BIT] != s_q.cm_en);
   assign too_early = s_q.low_en & (s_q.cnt < LOWER_TICKS);
   assign upper = UPPER_BASE << s_q.win;
   assign cnt_inc = s_q.cnt + 17'h0_0001;

   // Read view never exposes the key
   assign svc_rdata = {s_q.win, KEY_READ, s_q.cm_en};
   assign fault_pin_o = 1'b0;
   assign fault_pin_oe = s_q.oe;

   // ============================================================
   // Next state
   always_comb begin
      s_d = s_q;
      s_d.pin_s1 = fault_pin_i;
      s_d.pin_s2 = s_q.pin_s1;
      s_d.rate_s1 = clk_rate_low;
      s_d.rate_s2 = s_q.rate_s1;
      s_d.lp_q = low_pwr;
      // Monitor release delay restarts on every new error
      if (cm_err) begin
         s_d.cm_drv = 1'b1;
         s_d.cm_hold = 6'h00;
      end else if (s_q.cm_drv) begin
         if (s_q.cm_hold == REL_CYC - 6'h01) begin
            s_d.cm_drv = 1'b0;
         end else begin
            s_d.cm_hold = s_q.cm_hold + 6'h01;
         end
      end
      unique case (s_q.st)
         WD_RUN: begin
            if (boot_entry) begin
               s_d.cnt = 17'h0_0000;
               s_d.low_en = 1'b0;
            end else if (lp_exit) begin
               s_d.cnt = 17'h0_0000;
            end else if (accept) begin
               if (key_bad) begin
                  s_d.st = WD_DRIVE;
               end else if (!s_q.locked) begin
                  // One-time configuration, lower bound skipped
                  s_d.locked = 1'b1;
                  s_d.win = svc_wdata[WIN_MSB:WIN_LSB];
                  s_d.cm_en = svc_wdata[CM_BIT];
                  s_d.cnt = 17'h0_0000;
                  s_d.low_en = 1'b1;
               end else if (cfg_bad || too_early) begin
                  s_d.st = WD_DRIVE;
               end else begin
                  s_d.cnt = 17'h0_0000;
                  s_d.low_en = 1'b1;
               end
            end else if (tick_run) begin
               if (cnt_inc == upper) begin
                  s_d.st = WD_DRIVE;
               end else begin
                  s_d.cnt = cnt_inc;
               end
            end
         end
         WD_DRIVE: begin
            // Hold starts once the pad is really seen low
            if (pin_low) begin
               s_d.st = WD_HOLD;
               s_d.hold = 6'h00;
            end
         end
         WD_HOLD: begin
            if (s_q.hold == REL_CYC - 6'h01) begin
               s_d.st = WD_WAIT;
            end else begin
               s_d.hold = s_q.hold + 6'h01;
            end
         end
         WD_WAIT: begin
            // Monitor may still hold the pin; wait for it
            if (!pin_low) begin
               s_d.st = WD_RUN;
               s_d.cnt = 17'h0_0000;
            end
         end
      endcase
      if (!wd_en) begin
         s_d.st = WD_RUN;
         s_d.cnt = 17'h0_0000;
         s_d.cm_drv = 1'b0;
      end
      // Registered enable avoids glitches on the pad
      s_d.oe = wd_en & (s_d.cm_drv | (s_d.st == WD_DRIVE) | (s_d.st == WD_HOLD));
   end

   // ============================================================
   // State register; armed with widest window and monitor on
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{locked: 1'b0, win: WIN_RST, cm_en: CM_RST, low_en: 1'b0,
                  cnt: 17'h0_0000, st: WD_RUN, hold: 6'h00, cm_hold: 6'h00,
                  cm_drv: 1'b0, pin_s1: 1'b1, pin_s2: 1'b1, rate_s1: 1'b0,
                  rate_s2: 1'b0, lp_q: 1'b0, oe: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // ============================================================
   // Assertions
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence enter_hold_s;
      s_q.st == WD_DRIVE && pin_low && wd_en;
   endsequence

   sequence hold_run_s;
      (s_q.st == WD_HOLD && s_q.oe)[*8];
   endsequence

   key_check_a: assert property (
      accept && !boot_entry && !lp_exit && key_bad |=> s_q.st == WD_DRIVE ##1 s_q.oe
   ) else $error("bad key did not raise fault");

   first_lock_a: assert property (
      accept && !boot_entry && !lp_exit && !key_bad && !s_q.locked
      |=> s_q.locked && s_q.win == $past(svc_wdata[7:6])
          && s_q.cm_en == $past(svc_wdata[0])
   ) else $error("first service did not latch config");

   locked_hold_a: assert property (
      s_q.locked |=> s_q.locked && $stable(s_q.win) && $stable(s_q.cm_en)
   ) else $error("locked config changed");

   upper_err_a: assert property (
      s_q.st == WD_RUN && wd_en && tick_run && !accept && !boot_entry && !lp_exit
      && s_q.cnt == upper - 17'h0_0001 |=> s_q.st == WD_DRIVE
   ) else $error("upper limit not enforced");

   lower_err_a: assert property (
      accept && !boot_entry && !lp_exit && s_q.locked && !key_bad && !cfg_bad
      && s_q.low_en && s_q.cnt < 17'h0_0800 |=> s_q.st == WD_DRIVE
   ) else $error("early service not flagged");

   valid_restart_a: assert property (
      accept && !boot_entry && !lp_exit && s_q.locked && !key_bad && !cfg_bad
      && !too_early |=> s_q.st == WD_RUN && s_q.cnt == 17'h0_0000
   ) else $error("valid service did not restart");

   ignore_svc_a: assert property (
      svc_wr && s_q.st != WD_RUN && wd_en |=> $stable(s_q.locked) && $stable(s_q.win)
   ) else $error("service accepted while fault active");

   release_seq_a: assert property (
      enter_hold_s |=> hold_run_s ##17 s_q.st == WD_WAIT
   ) else $error("fault hold length wrong");

   monitor_drive_a: assert property (
      cm_err && wd_en |=> s_q.oe [*2]
   ) else $error("clock error did not drive pin");

   boot_service_a: assert property (
      boot_entry && s_q.st == WD_RUN && wd_en |=> s_q.cnt == 17'h0_0000 && !s_q.low_en
   ) else $error("boot entry did not service");

   key_read_a: assert property (
      svc_rdata[5:1] == 5'h00
   ) else $error("key visible on read");

   low_power_a: assert property (
      low_pwr && wd_en && s_q.st == WD_RUN && !accept && !boot_entry |=> $stable(s_q.cnt)
   ) else $error("count ran in low power");

   option_off_a: assert property (
      !wd_en |=> !s_q.oe
   ) else $error("pin driven with watchdog disabled");

   // ============================================================
   // Fault pin and window counter checks
   sequence restart_s;
      s_q.st == WD_RUN && s_q.cnt == 17'h0_0000;
   endsequence

   sequence cm_idle_s;
      !s_q.cm_drv;
   endsequence

   // Pad is pulled low from the first fault cycle on
   drive_oe_a: assert property (
      s_q.st == WD_DRIVE && wd_en |-> s_q.oe
   ) else $error("fault state without pad drive");

   // Hold counter never passes the chosen release delay
   hold_bound_a: assert property (
      s_q.st == WD_HOLD |-> s_q.hold < REL_CYC
   ) else $error("hold counter overran");

   // Pad released once hold is over, unless the monitor drives
   wait_oe_a: assert property (
      s_q.st == WD_WAIT && !s_q.cm_drv |-> !s_q.oe
   ) else $error("pad still driven after hold");

   // Only a low level is ever put on the pad
   pin_low_only_a: assert property (
      fault_pin_o == 1'b0
   ) else $error("pad driven high");

   // Window restarts when the pad is seen high again
   wait_restart_a: assert property (
      s_q.st == WD_WAIT && !pin_low && wd_en |=> restart_s
   ) else $error("window not restarted after fault");

   // First keyed write also restarts the window
   lock_run_a: assert property (
      accept && !boot_entry && !lp_exit && !key_bad && !s_q.locked |=> restart_s
   ) else $error("first service did not restart");

   // After boot entry an early valid service is no error
   boot_lower_a: assert property (
      accept && !boot_entry && !lp_exit && s_q.locked && !s_q.low_en
      && !key_bad && !cfg_bad |=> restart_s
   ) else $error("lower window not suppressed");

   // A monitor error starts a fresh release delay
   cm_set_a: assert property (
      cm_err && wd_en |=> s_q.cm_drv && s_q.cm_hold == 6'h00
   ) else $error("clock error not held");

   // Release delay counts one per cycle after recovery
   cm_count_a: assert property (
      s_q.cm_drv && !cm_err && wd_en && s_q.cm_hold != REL_CYC - 6'h01
      |=> s_q.cm_drv && s_q.cm_hold == $past(s_q.cm_hold) + 6'h01
   ) else $error("monitor delay did not count");

   // Monitor lets go at the end of the delay
   cm_release_a: assert property (
      s_q.cm_drv && !cm_err && wd_en && s_q.cm_hold == REL_CYC - 6'h01 |=> cm_idle_s
   ) else $error("monitor did not release");

   // Disabled monitor never reports
   cm_gate_a: assert property (
      !s_q.cm_en |-> !cm_err
   ) else $error("disabled monitor flagged");

   // Leaving low power is a hardware service
   lp_service_a: assert property (
      lp_exit && s_q.st == WD_RUN && wd_en && !boot_entry |=> s_q.cnt == 17'h0_0000
   ) else $error("low power exit did not service");

   // One idle tick moves the count by exactly one
   tick_step_a: assert property (
      tick_run && s_q.st == WD_RUN && wd_en && !accept && !boot_entry && !lp_exit
      && cnt_inc != upper |=> s_q.cnt == $past(cnt_inc)
   ) else $error("count did not follow idle tick");

   // Without a tick the count stands
   no_tick_a: assert property (
      !idle_tick && s_q.st == WD_RUN && wd_en && !accept && !boot_entry && !lp_exit
      |=> $stable(s_q.cnt)
   ) else $error("count moved without tick");

   // Running count stays below the selected upper limit
   below_upper_a: assert property (
      s_q.st == WD_RUN |-> s_q.cnt < upper
   ) else $error("count passed upper limit");

endmodule : wdcm_top
